// [hdl/tws_slave.sv]
`timescale 1ns/1ps
`include "tws_map.svh"
// How it works
// - Sample data on rising clock edges, change own data after falling edges.
// - Bytes go MSB first, eight data clocks plus one acknowledge clock.
// - Data changes only while clock low; changes while high mark Start or Stop.
// - Data falling with clock high is Start; ignore everything until one.
// - Data rising with clock high is Stop; end transfer, go idle.
// - A repeated Start ends the transfer and begins a new one directly.
// - Bus idle only with both lines high together.
// - Bytes per transfer are unlimited; the master decides.
// - Acknowledge received bytes by holding data low through the ninth clock.
// - Master high in acknowledge ends a read; device releases the data line.
// - Invalid operations may be answered with no-acknowledge.
// - Enter standby at power-up and after Stop once work is done.
// - Power-on initialisation completes within 10.0 ms.
// - Reset defaults: pointer 00h, comparator mode, zero hysteresis, alarm off.
// - Measurement enable rises once initialisation completes, no command needed.
// - Clock low beyond the stall limit resets the interface and releases data.
// - After a stall timeout, be ready for a new Start promptly.
// - Start, nine clocks, Start then Stop returns the device to idle.
// - Address byte: type code, three strap bits, read/write bit.
// - Acknowledge a matching address; on mismatch stay released, fall to standby.
module tws_slave
  import tws_pkg::*;
#(
  parameter int INIT_CYCLES =
    int'(`TWS_INIT_TIME_MS * 1000.0 * `TWS_CLK_MHZ),
  parameter int STALL_CYCLES =
    int'(`TWS_STALL_MIN_MS * 1000.0 * `TWS_CLK_MHZ),
  parameter int FILT_CYCLES = (`TWS_GLITCH_NS * `TWS_CLK_MHZ + 999) / 1000
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic [2:0] addrStrap,
  output logic sdaOut,
  output logic sdaOe,
  output logic standby,
  output logic initDone,
  output logic measureEn
);

  localparam logic [3:0] FILT_LAST = 4'(FILT_CYCLES - 1);
  localparam logic [31:0] STALL_LAST = 32'(STALL_CYCLES - 1);
  localparam logic [31:0] INIT_LAST = 32'(INIT_CYCLES - 1);

  logic [1:0] meta_ff, sync_ff;
  logic filt_ff [2];
  tws_line_type line, prev_ff;
  logic [2:0] strapMeta_ff, strap_ff;
  tws_state_type state_ff;
  logic [3:0] bitCnt_ff;
  logic [7:0] shift_ff, txShift_ff, txData_ff, rxData_ff, wrAddr_ff;
  logic rw_ff, ackDrive_ff, mAck_ff, sdaOe_ff, sdaOut_ff;
  logic [1:0] type_ff;
  logic [31:0] stallCnt_ff, initCnt_ff, hrdata_ff, statusWord;
  logic initDone_ff, measureEn_ff, standby_ff, ctrlNack_ff;
  logic rxNew_ff, txTaken_ff, timeoutFlag_ff, wrPend_ff;
  tws_cfg_type cfg_ff;
  logic hreadyout_ff, hresp_ff;
  logic sclRise, sclFall, startDet, stopDet, stallHit;
  logic addrHit, byteEnd, txLoad, busTake, rdRx;

  // Map a type code to an index; zero means not ours
  function automatic logic [1:0] typeIdx(input logic [3:0] code);
    unique case (code)
      `TWS_TYPE_MEM: typeIdx = 2'h1;
      `TWS_TYPE_PAGE: typeIdx = 2'h2;
      `TWS_TYPE_SENS: typeIdx = 2'h3;
      default: typeIdx = 2'h0;
    endcase
  endfunction : typeIdx

  // Two-stage synchronisers; lines reset high as an idle bus would be
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 2'h3;
      sync_ff <= 2'h3;
      strapMeta_ff <= 3'h0;
      strap_ff <= 3'h0;
    end else begin
      meta_ff <= {scl, sdaIn};
      sync_ff <= meta_ff;
      strapMeta_ff <= addrStrap;
      strap_ff <= strapMeta_ff;
    end
  end

  // Deglitch: a level must hold for the filter length before it counts
  for (genvar i = 0; i < 2; i++) begin : g_filt
    logic [3:0] cnt_ff;
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        filt_ff[i] <= 1'b1;
        cnt_ff <= 4'h0;
      end else if (sync_ff[i] == filt_ff[i]) begin
        cnt_ff <= 4'h0;
      end else if (cnt_ff == FILT_LAST) begin
        filt_ff[i] <= sync_ff[i];
        cnt_ff <= 4'h0;
      end else begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end

  // Both lines share one filter delay, so setup between them is kept
  assign line = {filt_ff[1], filt_ff[0]};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= 2'h3;
    end else begin
      prev_ff <= line;
    end
  end

  // Edge and condition detection on the filtered lines
  assign sclRise = line.scl & ~prev_ff.scl;
  assign sclFall = ~line.scl & prev_ff.scl;
  assign startDet = line.scl & prev_ff.scl & prev_ff.sda & ~line.sda;
  assign stopDet = line.scl & prev_ff.scl & ~prev_ff.sda & line.sda;
  assign addrHit = (typeIdx(shift_ff[7:4]) != 2'h0) &&
                   (shift_ff[3:1] == strap_ff);
  assign byteEnd = sclFall && (bitCnt_ff == 4'h8);
  assign stallHit = (stallCnt_ff == STALL_LAST);

  // Power-on wait; the bus is ignored until it runs out
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      initCnt_ff <= 32'h0;
      initDone_ff <= 1'b0;
      measureEn_ff <= 1'b0;
    end else begin
      if (!initDone_ff) begin
        initCnt_ff <= initCnt_ff + 32'h1;
      end
      if (initCnt_ff == INIT_LAST) begin
        initDone_ff <= 1'b1;
      end
      measureEn_ff <= initDone_ff;
    end
  end

  // Stall timer runs only while clock is low inside a transfer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stallCnt_ff <= 32'h0;
    end else if (line.scl || state_ff == ST_IDLE || stallHit) begin
      stallCnt_ff <= 32'h0;
    end else begin
      stallCnt_ff <= stallCnt_ff + 32'h1;
    end
  end

  // Serial engine; Stop and timeout outrank Start, Start outranks bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      bitCnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      rw_ff <= 1'b0;
      ackDrive_ff <= 1'b0;
      mAck_ff <= 1'b0;
      type_ff <= 2'h0;
    end else if (!initDone_ff || stallHit || stopDet) begin
      state_ff <= ST_IDLE;
      bitCnt_ff <= 4'h0;
    end else if (startDet) begin
      state_ff <= ST_ADDR;
      bitCnt_ff <= 4'h0;
    end else begin
      if (sclRise) begin
        shift_ff <= {shift_ff[6:0], line.sda};
        bitCnt_ff <= bitCnt_ff + 4'h1;
        if (state_ff == ST_MACK) begin
          mAck_ff <= ~line.sda;
        end
      end
      if (sclFall) begin
        unique case (state_ff)
          ST_ADDR: if (byteEnd) begin
            bitCnt_ff <= 4'h0;
            if (addrHit) begin
              state_ff <= ST_ACK;
              ackDrive_ff <= 1'b1;
              rw_ff <= shift_ff[0];
              type_ff <= typeIdx(shift_ff[7:4]);
            end else begin
              state_ff <= ST_SKIP;
            end
          end
          ST_RX: if (byteEnd) begin
            bitCnt_ff <= 4'h0;
            state_ff <= ST_ACK;
            ackDrive_ff <= ~ctrlNack_ff;
          end
          ST_ACK: begin
            bitCnt_ff <= 4'h0;
            if (!ackDrive_ff) begin
              state_ff <= ST_SKIP;
            end else begin
              state_ff <= rw_ff ? ST_TX : ST_RX;
            end
          end
          ST_TX: if (byteEnd) begin
            bitCnt_ff <= 4'h0;
            state_ff <= ST_MACK;
          end
          ST_MACK: begin
            bitCnt_ff <= 4'h0;
            state_ff <= mAck_ff ? ST_TX : ST_SKIP;
          end
          ST_IDLE, ST_SKIP: begin
          end
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // Load point for a new transmit byte
  assign txLoad = sclFall && initDone_ff && !stallHit && !stopDet &&
                  !startDet &&
                  ((state_ff == ST_ACK && ackDrive_ff && rw_ff) ||
                   (state_ff == ST_MACK && mAck_ff));

  // Data line drive; changes only on a falling clock or on release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdaOe_ff <= 1'b0;
      sdaOut_ff <= 1'b0;
      txShift_ff <= 8'h00;
    end else if (!initDone_ff || stallHit || stopDet || startDet) begin
      sdaOe_ff <= 1'b0;
    end else if (txLoad) begin
      txShift_ff <= txData_ff;
      sdaOe_ff <= ~txData_ff[7];
    end else if (sclFall) begin
      unique case (state_ff)
        ST_ADDR: sdaOe_ff <= byteEnd && addrHit;
        ST_RX: sdaOe_ff <= byteEnd && !ctrlNack_ff;
        ST_TX: if (byteEnd) begin
          sdaOe_ff <= 1'b0;
        end else begin
          txShift_ff <= {txShift_ff[6:0], 1'b0};
          sdaOe_ff <= ~txShift_ff[6];
        end
        default: sdaOe_ff <= 1'b0;
      endcase
    end
  end

  // No internal work is pending here, so standby follows the state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      standby_ff <= 1'b1;
    end else begin
      standby_ff <= (state_ff == ST_IDLE) || (state_ff == ST_SKIP);
    end
  end

  // Bus slave: zero wait, read data registered in the address phase
  assign busTake = hsel && htrans[1] && hready;
  assign rdRx = busTake && !hwrite && (haddr[7:0] == `TWS_OFS_RXDATA);
  assign statusWord = {17'h0, standby_ff, initDone_ff, rxNew_ff,
                       txTaken_ff, timeoutFlag_ff, type_ff, rw_ff,
                       state_ff};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_ff <= 1'b0;
      wrAddr_ff <= 8'h00;
      hrdata_ff <= 32'h0;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      wrPend_ff <= busTake && hwrite;
      if (busTake) begin
        wrAddr_ff <= haddr[7:0];
      end
      if (busTake && !hwrite) begin
        unique case (haddr[7:0])
          `TWS_OFS_CTRL: hrdata_ff <= {31'h0, ctrlNack_ff};
          `TWS_OFS_STATUS: hrdata_ff <= statusWord;
          `TWS_OFS_TXDATA: hrdata_ff <= {24'h0, txData_ff};
          `TWS_OFS_RXDATA: hrdata_ff <= {23'h0, rxNew_ff, rxData_ff};
          `TWS_OFS_CONFIG: hrdata_ff <= {18'h0, cfg_ff};
          default: hrdata_ff <= 32'h0;
        endcase
      end
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  // Software-owned settings, written in the data phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlNack_ff <= `TWS_CTRL_RST;
      txData_ff <= 8'h00;
      cfg_ff <= `TWS_CFG_RST;
    end else if (wrPend_ff) begin
      if (wrAddr_ff == `TWS_OFS_CTRL) begin
        ctrlNack_ff <= hwdata[`TWS_CTRL_NACK];
      end
      if (wrAddr_ff == `TWS_OFS_TXDATA) begin
        txData_ff <= hwdata[7:0];
      end
      if (wrAddr_ff == `TWS_OFS_CONFIG) begin
        cfg_ff <= hwdata[`TWS_CFG_W-1:0];
      end
    end
  end

  // Sticky flags; a hardware set wins over a software clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxData_ff <= 8'h00;
      rxNew_ff <= 1'b0;
      txTaken_ff <= 1'b0;
      timeoutFlag_ff <= 1'b0;
    end else begin
      if (state_ff == ST_RX && byteEnd && !stopDet && !startDet) begin
        rxData_ff <= shift_ff;
        rxNew_ff <= 1'b1;
      end else if (rdRx) begin
        rxNew_ff <= 1'b0;
      end
      if (txLoad) begin
        txTaken_ff <= 1'b1;
      end else if (wrPend_ff && wrAddr_ff == `TWS_OFS_TXDATA) begin
        txTaken_ff <= 1'b0;
      end
      if (stallHit) begin
        timeoutFlag_ff <= 1'b1;
      end else if (wrPend_ff && wrAddr_ff == `TWS_OFS_STATUS &&
                   hwdata[`TWS_STAT_BUS_STALL_LIMIT]) begin
        timeoutFlag_ff <= 1'b0;
      end
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign sdaOut = sdaOut_ff;
  assign sdaOe = sdaOe_ff;
  assign standby = standby_ff;
  assign initDone = initDone_ff;
  assign measureEn = measureEn_ff;

  // Checks on the serial engine
  property p_start;
    @(posedge ref_clk) disable iff (!rst_n)
    (startDet && initDone_ff && !stopDet && !stallHit)
      |=> (state_ff == ST_ADDR) && (bitCnt_ff == 4'h0) && !sdaOe_ff;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_stop;
    @(posedge ref_clk) disable iff (!rst_n)
    stopDet |=> (state_ff == ST_IDLE) ##1 standby_ff;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not idle");

  property p_oeMoves;
    @(posedge ref_clk) disable iff (!rst_n)
    $changed(sdaOe_ff) |->
      $past(sclFall || startDet || stopDet || stallHit || !initDone_ff);
  endproperty
  a_oeMoves: assert property (p_oeMoves) else $error("sda moved early");

  property p_ninth;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_ff == ST_ADDR && byteEnd && !startDet && !stopDet && !stallHit)
      |=> (state_ff == ST_ACK) || (state_ff == ST_SKIP);
  endproperty
  a_ninth: assert property (p_ninth) else $error("no ack after 8 bits");

  property p_ackHold;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_ff == ST_ACK && ackDrive_ff && line.scl && !startDet &&
     !stopDet) |-> sdaOe_ff;
  endproperty
  a_ackHold: assert property (p_ackHold) else $error("ack not low");

  property p_nackRel;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_ff == ST_MACK && sclFall && !mAck_ff && initDone_ff)
      |=> !sdaOe_ff [*2];
  endproperty
  a_nackRel: assert property (p_nackRel) else $error("nack kept sda");

  property p_mismatch;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_ff == ST_ADDR && byteEnd && !addrHit && initDone_ff &&
     !stallHit) |=> (state_ff == ST_SKIP) && !sdaOe_ff ##1 standby_ff;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("bad addr");

  property p_timeout;
    @(posedge ref_clk) disable iff (!rst_n)
    stallHit |=> (state_ff == ST_IDLE) && !sdaOe_ff && timeoutFlag_ff;
  endproperty
  a_timeout: assert property (p_timeout) else $error("stall missed");

  property p_initQuiet;
    @(posedge ref_clk) disable iff (!rst_n)
    !initDone_ff |-> (state_ff == ST_IDLE) && !sdaOe_ff && !measureEn_ff;
  endproperty
  a_initQuiet: assert property (p_initQuiet) else $error("early bus");

  property p_measure;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(initDone_ff) |=> measureEn_ff;
  endproperty
  a_measure: assert property (p_measure) else $error("no measure");

  c_ack: cover property (@(posedge ref_clk) disable iff (!rst_n)
    state_ff == ST_ADDR ##1 state_ff == ST_ACK);
  c_read: cover property (@(posedge ref_clk) disable iff (!rst_n)
    state_ff == ST_MACK ##1 state_ff == ST_TX);
  c_stall: cover property (@(posedge ref_clk) disable iff (!rst_n)
    stallHit);

endmodule : tws_slave

// [pkg/tws_map.svh]
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH
// Timing figures and the clock rate that turns them into cycles
`define TWS_CLK_MHZ 100
`define TWS_INIT_TIME_MS 10.0
`define TWS_STALL_MIN_MS 25.0
`define TWS_GLITCH_NS 20
// Register byte offsets
`define TWS_OFS_CTRL 8'h00
`define TWS_OFS_STATUS 8'h04
`define TWS_OFS_TXDATA 8'h08
`define TWS_OFS_RXDATA 8'h0c
`define TWS_OFS_CONFIG 8'h10
// Field positions
`define TWS_CTRL_NACK 0
`define TWS_STAT_BUS_STALL_LIMIT 10
`define TWS_CFG_W 14
// Reset values
`define TWS_CTRL_RST 1'b0
`define TWS_CFG_RST 14'h0000
// Function type codes of the address byte
`define TWS_TYPE_MEM 4'ha
`define TWS_TYPE_PAGE 4'h6
`define TWS_TYPE_SENS 4'h3
`endif

// [pkg/tws_pkg.sv]
package tws_pkg;
  // Serial engine states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ACK = 7'h04,
    ST_RX = 7'h08,
    ST_TX = 7'h10,
    ST_MACK = 7'h20,
    ST_SKIP = 7'h40
  } tws_state_type;
  // Filtered bus lines travel together
  typedef struct packed {
    logic scl;
    logic sda;
  } tws_line_type;
  // Configuration defaults held for the sensor side
  typedef struct packed {
    logic alarmEn;
    logic alarmPolHigh;
    logic [1:0] hyst;
    logic alarmIntMode;
    logic pageSel;
    logic [7:0] pointer;
  } tws_cfg_type;
endpackage : tws_pkg

// [sim/tws_master_model.sv]
`timescale 1ns/1ps
// Two-wire bus master: drives the clock, pulls data low or lets it float
module tws_master_model (
  input wire logic ref_clk,
  input wire logic sdaPin,
  output logic scl,
  output logic sdaLow
);
  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'h1;
    sdaLow = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  // Data moves only while the clock is low
  // The low phase is stretched to 6 cycles because the device needs
  // about 5 cycles to turn its data around
  task automatic bitIo(input logic b, output logic s);
    tick(1);
    sdaLow <= ~b;
    tick(5);
    scl <= 1'h1;
    tick(4);
    s = sdaPin;
    scl <= 1'h0;
  endtask : bitIo
  // Eight bits MSB first, then the ninth clock, no gaps
  task automatic xfer(input logic [7:0] tx, input logic ackBit,
    output logic [7:0] rx, output logic ackSeen);
    for (int i = 7; i >= 0; i--) begin
      bitIo(tx[i], rx[i]);
    end
    bitIo(ackBit, ackSeen); // A 1 releases the line
  endtask : xfer
  // Also serves as repeated Start once the device has let go
  task automatic start();
    tick(1);
    sdaLow <= 1'h0;
    tick(6);
    scl <= 1'h1;
    tick(4);
    sdaLow <= 1'h1;
    tick(4);
    scl <= 1'h0;
  endtask : start
  task automatic stop();
    tick(1);
    sdaLow <= 1'h1;
    tick(6);
    scl <= 1'h1;
    tick(4);
    sdaLow <= 1'h0;
    tick(4);
  endtask : stop
  // Clock held low with data released
  task automatic stall(input int n);
    tick(1);
    sdaLow <= 1'h0;
    tick(n);
  endtask : stall
endmodule : tws_master_model

// [sim/tws_slave_tb.sv]
`timescale 1ns/1ps
`include "tws_map.svh"
module tws_slave_tb;
  import tws_pkg::*;
  localparam int INIT_N = 50;
  localparam int STALL_N = 200;
  // One address byte per row and the level the master should see
  typedef struct packed {
    logic [3:0] ty;
    logic [2:0] ad;
    logic rw;
    logic ack;
  } tws_row_type;
  tws_row_type rows [6];
  logic ref_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, addrStrap;
  logic sdaOut, sdaOe, standby, initDone, measureEn;
  logic scl, sdaLow, sdaPin, ak, lastOe;
  logic [7:0] rx;
  int errTotal = 0;
  int samplesChecked = 0;
  int hiCnt = 0;
  int n;
  // Open-drain wire with pull-up; single slave closes the ready loop
  assign sdaPin = !((sdaOe && !sdaOut) || sdaLow);
  assign hready = hreadyout;
  tws_slave #(.INIT_CYCLES(INIT_N), .STALL_CYCLES(STALL_N)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .scl(scl), .sdaIn(sdaPin), .addrStrap(addrStrap),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .standby(standby),
    .initDone(initDone), .measureEn(measureEn)
  );
  tws_master_model u_mst (
    .ref_clk(ref_clk), .sdaPin(sdaPin), .scl(scl), .sdaLow(sdaLow)
  );
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  task automatic miss(input string m);
    errTotal++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : miss
  task automatic chkBit(input string m, input logic g, input logic e);
    samplesChecked++;
    if (g !== e) miss(m);
  endtask : chkBit
  task automatic chkWord(input string m, input logic [31:0] g,
    input logic [31:0] e);
    samplesChecked++;
    if (g !== e) miss(m);
  endtask : chkWord
  task automatic tk(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : tk
  // Bounded wait so a stuck slave ends the run instead of hanging it
  task automatic waitRdy();
    int k;
    k = 0;
    @(posedge ref_clk);
    while (hready !== 1'h1) begin
      k++;
      if (k > 20) begin
        miss("bus wait");
        conclude();
      end
      @(posedge ref_clk);
    end
  endtask : waitRdy
  // Single word: address phase, then data phase; read data at its end
  task automatic ahb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    waitRdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitRdy();
    rd = hrdata;
  endtask : ahb
  // Device data must not move once the clock has been high a while
  always @(posedge ref_clk) begin
    hiCnt <= scl ? hiCnt + 1 : 0;
    lastOe <= sdaOe;
    if (rst_n && hiCnt > 1 && sdaOe !== lastOe) begin
      miss("data moved in high phase");
    end
  end
  initial begin
    rst_n = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    addrStrap = 3'h5;
    rows = '{'{4'ha, 3'h5, 1'h0, 1'h0}, '{4'h6, 3'h5, 1'h0, 1'h0},
      '{4'h3, 3'h5, 1'h0, 1'h0}, '{4'ha, 3'h4, 1'h0, 1'h1},
      '{4'h5, 3'h5, 1'h0, 1'h1}, '{4'h3, 3'h5, 1'h1, 1'h0}};
    tk(2);
    chkBit("standby", standby, 1'h1);
    chkBit("oe", sdaOe, 1'h0);
    chkBit("init", initDone, 1'h0);
    chkBit("meas", measureEn, 1'h0);
    chkBit("ready", hreadyout, 1'h1);
    chkBit("okay", hresp, 1'h0);
    chkBit("sda level", sdaOut, 1'h0);
    tk(2);
    rst_n <= 1'h1;
    n = 0;
    while (initDone !== 1'h1 && n <= INIT_N + 9) begin
      tk(1);
      n++;
    end
    chkBit("init time", n >= INIT_N && n <= INIT_N + 2, 1'h1);
    tk(1);
    chkBit("meas", measureEn, 1'h1);
    ahb(1'h0, `TWS_OFS_CONFIG, 32'h0);
    chkWord("config", rd, 32'h0);
    ahb(1'h1, `TWS_OFS_CONFIG, 32'h3fff);
    ahb(1'h0, `TWS_OFS_CONFIG, 32'h0);
    chkWord("config rw", rd, 32'h3fff);
    ahb(1'h1, `TWS_OFS_CONFIG, 32'h0);
    ahb(1'h0, `TWS_OFS_STATUS, 32'h0);
    chkWord("status", rd, 32'h6001);
    ahb(1'h1, 8'h40, 32'hffffffff);
    ahb(1'h0, 8'h40, 32'h0);
    chkWord("unmapped", rd, 32'h0);
    ahb(1'h1, `TWS_OFS_TXDATA, 32'hc5);
    // Ordinary address and data cases from the table
    for (int i = 0; i < 6; i++) begin
      u_mst.start();
      u_mst.xfer({rows[i].ty, rows[i].ad, rows[i].rw}, 1'h1, rx, ak);
      chkBit("addr ack", ak, rows[i].ack);
      if (rows[i].ack === 1'h1) begin
        tk(8);
        chkBit("skip standby", standby, 1'h1);
      end else if (rows[i].rw === 1'h1) begin
        u_mst.xfer(8'hff, 1'h1, rx, ak);
        chkWord("read byte", {24'h0, rx}, 32'hc5);
        tk(8);
        chkBit("released", sdaOe, 1'h0);
      end else begin
        u_mst.xfer(8'h96, 1'h1, rx, ak);
        chkBit("data ack", ak, 1'h0);
        u_mst.xfer(8'h3b, 1'h1, rx, ak);
        chkBit("data ack", ak, 1'h0);
        ahb(1'h0, `TWS_OFS_RXDATA, 32'h0);
        chkWord("rx data", rd, 32'h13b);
      end
      u_mst.stop();
      tk(10);
      chkBit("standby", standby, 1'h1);
      ahb(1'h0, `TWS_OFS_STATUS, 32'h0);
      chkWord("idle", rd & 32'h7f, 32'h1);
    end
    // Refused byte, then repeated Start with no Stop between
    ahb(1'h1, `TWS_OFS_CTRL, 32'h1);
    u_mst.start();
    u_mst.xfer(8'h6a, 1'h1, rx, ak);
    chkBit("addr ack", ak, 1'h0);
    u_mst.xfer(8'h55, 1'h1, rx, ak);
    chkBit("refused", ak, 1'h1);
    ahb(1'h1, `TWS_OFS_CTRL, 32'h0);
    u_mst.start();
    u_mst.xfer(8'haa, 1'h1, rx, ak);
    chkBit("restart ack", ak, 1'h0);
    chkBit("no standby", standby, 1'h0);
    u_mst.xfer(8'h96, 1'h1, rx, ak);
    chkBit("data ack", ak, 1'h0);
    u_mst.stop();
    // Clock stalled while the device holds data low
    ahb(1'h1, `TWS_OFS_TXDATA, 32'h3c);
    u_mst.start();
    u_mst.xfer(8'h3b, 1'h1, rx, ak);
    chkBit("addr ack", ak, 1'h0);
    tk(8);
    chkBit("drives bit", sdaOe, 1'h1);
    u_mst.stall(STALL_N + 20);
    chkBit("released", sdaOe, 1'h0);
    ahb(1'h0, `TWS_OFS_STATUS, 32'h0);
    chkWord("bus_stall_limit flag", rd & 32'h47f, 32'h401);
    ahb(1'h1, `TWS_OFS_STATUS, 32'h400);
    ahb(1'h0, `TWS_OFS_STATUS, 32'h0);
    chkWord("bus_stall_limit clear", rd & 32'h400, 32'h0);
    u_mst.start();
    u_mst.xfer(8'h3a, 1'h1, rx, ak);
    chkBit("after bus_stall_limit", ak, 1'h0);
    // Recovery: Start, nine clocks, Start, Stop
    u_mst.start();
    for (int i = 0; i < 9; i++) begin
      u_mst.bitIo(1'h1, ak);
    end
    u_mst.start();
    u_mst.stop();
    tk(10);
    ahb(1'h0, `TWS_OFS_STATUS, 32'h0);
    chkWord("recovered", rd & 32'h407f, 32'h4001);
    conclude();
  end
endmodule : tws_slave_tb
